//--- rtl/desc_rom.sv
// Byte memory holding the fixed descriptor bytes and muxing in the input fields, read data registered.
`timescale 1ns/100ps
module desc_rom (
    input  wire logic       clk,
    input  wire logic [4:0] addr,
    input  wire logic [7:0] class_code,
    input  wire logic [7:0] subclass_code,
    input  wire logic [7:0] protocol_code,
    input  wire logic [7:0] max_packet0,
    input  wire logic [7:0] num_configs,
    output logic      [7:0] rd_data
);
    logic [7:0] byte_next;

    always_comb begin
        case (addr)
            dev_desc_pkg::OFS_LENGTH:      byte_next = {3'h0, dev_desc_pkg::DESC_LEN}; // [R10]
            dev_desc_pkg::OFS_TYPE:        byte_next = dev_desc_pkg::TYPE_DEVICE; // [R10]
            dev_desc_pkg::OFS_VERSION_LO:  byte_next = dev_desc_pkg::VERSION_2_0[7:0]; // [R3] [R5] [R11]
            dev_desc_pkg::OFS_VERSION_HI:  byte_next = dev_desc_pkg::VERSION_2_0[15:8]; // [R11]
            dev_desc_pkg::OFS_CLASS:       byte_next = class_code; // [R12]
            dev_desc_pkg::OFS_SUBCLASS:    byte_next = subclass_code; // [R15]
            dev_desc_pkg::OFS_PROTOCOL:    byte_next = protocol_code;
            dev_desc_pkg::OFS_MAX_PACKET0: byte_next = max_packet0; // [R8] [R17]
            5'h08:                         byte_next = dev_desc_pkg::VENDOR_ID[7:0];
            5'h09:                         byte_next = dev_desc_pkg::VENDOR_ID[15:8];
            5'h0A:                         byte_next = dev_desc_pkg::PRODUCT_ID[7:0];
            5'h0B:                         byte_next = dev_desc_pkg::PRODUCT_ID[15:8];
            5'h0C:                         byte_next = dev_desc_pkg::DEVICE_RELEASE[7:0];
            5'h0D:                         byte_next = dev_desc_pkg::DEVICE_RELEASE[15:8];
            dev_desc_pkg::OFS_NUM_CONFIGS: byte_next = num_configs; // [R18]
            default:                       byte_next = 8'h00;
        endcase
    end

    always_ff @(posedge clk) begin
        rd_data <= byte_next;
    end
endmodule

//--- rtl/dev_desc_pkg.sv
// Constants shared by the device descriptor source.
package dev_desc_pkg;
    // =========================================================================
    // Descriptor layout
    // =========================================================================
    localparam logic [4:0] DESC_LEN          = 5'h12;
    localparam logic [7:0] TYPE_DEVICE       = 8'h01;
    localparam logic [7:0] TYPE_QUALIFIER    = 8'h06;
    localparam logic [4:0] OFS_LENGTH        = 5'h00;
    localparam logic [4:0] OFS_TYPE          = 5'h01;
    localparam logic [4:0] OFS_VERSION_LO    = 5'h02;
    localparam logic [4:0] OFS_VERSION_HI    = 5'h03;
    localparam logic [4:0] OFS_CLASS         = 5'h04;
    localparam logic [4:0] OFS_SUBCLASS      = 5'h05;
    localparam logic [4:0] OFS_PROTOCOL      = 5'h06;
    localparam logic [4:0] OFS_MAX_PACKET0   = 5'h07;
    localparam logic [4:0] OFS_NUM_CONFIGS   = 5'h11;
    localparam logic [4:0] OFS_LAST          = 5'h11;
    // =========================================================================
    // Field values
    // =========================================================================
    localparam logic [15:0] VERSION_2_0      = 16'h0200;
    localparam logic [7:0]  CLASS_PER_IFACE  = 8'h00;
    localparam logic [7:0]  CLASS_VENDOR     = 8'hFF;
    localparam logic [7:0]  SUBCLASS_NONE    = 8'h00;
    localparam logic [7:0]  PACKET_HS        = 8'h40;
    localparam logic [7:0]  PACKET_8         = 8'h08;
    localparam logic [7:0]  PACKET_16        = 8'h10;
    localparam logic [7:0]  PACKET_32        = 8'h20;
    // Arbitrary neutral identity values.
    localparam logic [15:0] VENDOR_ID        = 16'h1234;
    localparam logic [15:0] PRODUCT_ID       = 16'h5678;
    localparam logic [15:0] DEVICE_RELEASE   = 16'h0100;

    typedef enum logic [1:0] {SPEED_LOW, SPEED_FULL, SPEED_HIGH} speed_t;
endpackage

//--- rtl/device_descriptor_source.sv
// Device descriptor source: streams the single device descriptor on request.
// How it works
// (R1) One descriptor image serves the whole device and all its configurations.
// (R2) Qualifier requests are flagged for the request logic when speeds differ.
// (R3) The version field always reads 0200H.
// (R4) Non-high-speed devices refuse qualifier requests with a request error.
// (R5) Version is BCD 0xJJMN: major, minor, sub-minor digits.
// (R6) Configuration count is the one for the current operating speed.
// (R7) At high speed the endpoint-zero packet size is forced to 64.
// (R8) Endpoint-zero packet size lives only in this descriptor.
// (R9) No endpoint-zero descriptor is produced by this block.
// (R10) Offset 0 is length 18, offset 1 is the device type.
// (R11) Version sits at offsets 2 and 3, low byte first.
// (R12) Class at offset 4; zero means interfaces declare their own class.
// (R13) Class 1 to FEH governs the aggregate interfaces.
// (R14) Class FFH marks a vendor-specific device.
// (R15) Subclass at offset 5, forced to zero when class is zero.
// (R16) Subclass passes unchanged for any nonzero class, not only FFH.
// (R17) Packet size at offset 7, restricted to 8, 16, 32 or 64.
// (R18) Configuration count is the last byte, offset 17.
// (R19) Bytes leave in ascending offset order starting with the length.
`timescale 1ns/100ps
module device_descriptor_source (
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic [1:0] speed,
    input  wire logic       qualifier_differs,
    input  wire logic [7:0] class_code,
    input  wire logic [7:0] subclass_code,
    input  wire logic [7:0] protocol_code,
    input  wire logic [7:0] packet_size_fs,
    input  wire logic [7:0] configs_hs,
    input  wire logic [7:0] configs_fs,
    input  wire logic       req_valid,
    input  wire logic [7:0] req_type,
    input  wire logic [4:0] req_length,
    output logic            req_ready,
    output logic            req_error,
    output logic            qualifier_needed,
    output logic            data_valid,
    output logic [7:0]      data_byte,
    output logic            data_last,
    input  wire logic       data_ready
);
    // =========================================================================
    // Field preparation
    // =========================================================================
    typedef enum {IDLE, FETCH, SEND} state_t;

    state_t     state_reg;
    logic [4:0] addr_reg;
    logic [4:0] limit_reg;
    logic       error_reg;
    logic [7:0] num_configs_reg;
    logic       high_speed;
    logic [7:0] class_fix;
    logic [7:0] subclass_fix;
    logic [7:0] packet_fix;
    logic [7:0] rom_byte;
    logic       accept;

    assign high_speed = (speed == 2'(dev_desc_pkg::SPEED_HIGH));
    assign accept     = req_valid && req_ready;
    assign req_ready  = (state_reg == IDLE);

    // Configuration count follows the current speed only.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            num_configs_reg <= 8'h00;
        end else begin
            num_configs_reg <= high_speed ? configs_hs : configs_fs; // [R6]
        end
    end

    field_check u_check (
        .clk          (clk),
        .reset_n      (reset_n),
        .class_in     (class_code),
        .subclass_in  (subclass_code),
        .packet_in    (packet_size_fs),
        .high_speed   (high_speed),
        .class_out    (class_fix),
        .subclass_out (subclass_fix),
        .packet_out   (packet_fix)
    );

    // One shared image serves every configuration.
    desc_rom u_rom (
        .clk           (clk),
        .addr          (addr_reg),
        .class_code    (class_fix),
        .subclass_code (subclass_fix),
        .protocol_code (protocol_code),
        .max_packet0   (packet_fix),
        .num_configs   (num_configs_reg),
        .rd_data       (rom_byte)
    ); // [R1] [R8] [R9]

    // =========================================================================
    // Request handling
    // =========================================================================
    // A qualifier request from a high-speed device is left to the request
    // logic; this block only raises the flag and sends nothing.
    assign qualifier_needed = high_speed && qualifier_differs; // [R2]

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            error_reg <= 1'b0;
        end else begin
            error_reg <= accept && (req_type != dev_desc_pkg::TYPE_DEVICE) &&
                         !(req_type == dev_desc_pkg::TYPE_QUALIFIER && high_speed); // [R4]
        end
    end
    assign req_error = error_reg;

    // =========================================================================
    // Byte streaming
    // =========================================================================
    // The memory read costs one cycle, so every byte passes through FETCH.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_reg <= IDLE;
            addr_reg  <= dev_desc_pkg::OFS_LENGTH;
            limit_reg <= dev_desc_pkg::OFS_LAST;
        end else begin
            case (state_reg)
                IDLE: begin
                    if (accept && req_type == dev_desc_pkg::TYPE_DEVICE && req_length != 5'h00) begin
                        state_reg <= FETCH;
                        addr_reg  <= dev_desc_pkg::OFS_LENGTH; // [R19]
                        limit_reg <= (req_length > dev_desc_pkg::DESC_LEN) ?
                                     dev_desc_pkg::OFS_LAST : 5'(req_length - 5'h01);
                    end
                end
                FETCH: begin
                    state_reg <= SEND;
                end
                SEND: begin
                    if (data_ready) begin
                        if (addr_reg == limit_reg) begin
                            state_reg <= IDLE;
                        end else begin
                            addr_reg  <= 5'(addr_reg + 5'h01); // [R19]
                            state_reg <= FETCH;
                        end
                    end
                end
                default: begin
                    state_reg <= IDLE;
                end
            endcase
        end
    end

    assign data_valid = (state_reg == SEND);
    assign data_last  = (state_reg == SEND) && (addr_reg == limit_reg);
    assign data_byte  = rom_byte;

    // =========================================================================
    // Checks
    // =========================================================================
    first_length_a: assert property (@(posedge clk) disable iff (!reset_n) // [R10]
        $rose(data_valid) && addr_reg == 5'h00 |-> data_byte == 8'h12)
        else $error("first byte is not the length");
    type_byte_a: assert property (@(posedge clk) disable iff (!reset_n) // [R10]
        data_valid && addr_reg == 5'h01 |-> data_byte == 8'h01)
        else $error("type byte wrong");
    version_low_a: assert property (@(posedge clk) disable iff (!reset_n) // [R3]
        data_valid && addr_reg == 5'h02 |-> data_byte == 8'h00)
        else $error("version low byte wrong");
    version_high_a: assert property (@(posedge clk) disable iff (!reset_n) // [R11]
        data_valid && addr_reg == 5'h03 |-> data_byte == 8'h02)
        else $error("version high byte wrong");
    hs_packet_a: assert property (@(posedge clk) disable iff (!reset_n) // [R7]
        data_valid && addr_reg == 5'h07 && $stable(speed) && high_speed |-> data_byte == 8'h40)
        else $error("high speed packet size not 64");
    legal_packet_a: assert property (@(posedge clk) disable iff (!reset_n) // [R17]
        data_valid && addr_reg == 5'h07 |->
        data_byte inside {8'h08, 8'h10, 8'h20, 8'h40})
        else $error("illegal packet size");
    zero_subclass_a: assert property (@(posedge clk) disable iff (!reset_n) // [R15]
        class_fix == 8'h00 |-> subclass_fix == 8'h00)
        else $error("subclass nonzero with zero class");
    ascending_order_a: assert property (@(posedge clk) disable iff (!reset_n) // [R19]
        data_valid && data_ready && !data_last |=> ##1 data_valid && addr_reg == $past(addr_reg, 2) + 5'h01)
        else $error("bytes out of order");
    qual_error_a: assert property (@(posedge clk) disable iff (!reset_n) // [R4]
        accept && req_type == 8'h06 && !high_speed |=> req_error)
        else $error("qualifier not refused");
    // The count register lags its inputs by one edge, so it is only compared once
    // the inputs have held for a cycle outside reset.
    configs_a: assert property (@(posedge clk) disable iff (!reset_n) // [R6]
        $past(reset_n) && $stable(speed) && $stable(configs_hs) && $stable(configs_fs) |->
        num_configs_reg == (high_speed ? configs_hs : configs_fs))
        else $error("config count not for current speed");
    device_no_error_a: assert property (@(posedge clk) disable iff (!reset_n) // [R1]
        accept && req_type == 8'h01 |=> !req_error)
        else $error("device request refused");
    hs_qual_silent_a: assert property (@(posedge clk) disable iff (!reset_n) // [R2]
        accept && req_type == 8'h06 && high_speed |=> !req_error && req_ready)
        else $error("high speed qualifier request not left to request logic");
    start_at_length_a: assert property (@(posedge clk) disable iff (!reset_n) // [R19]
        accept && req_type == 8'h01 && req_length != 5'h00 |=> ##1 data_valid && data_byte == 8'h12)
        else $error("descriptor does not start with the length");
    sub_on_wire_a: assert property (@(posedge clk) disable iff (!reset_n) // [R15]
        data_valid && addr_reg == 5'h05 && class_fix == 8'h00 |-> data_byte == 8'h00)
        else $error("subclass byte nonzero with zero class");
    last_configs_a: assert property (@(posedge clk) disable iff (!reset_n) // [R18]
        data_valid && addr_reg == 5'h11 |-> data_last && data_byte == (high_speed ? configs_hs : configs_fs))
        else $error("last byte is not the configuration count");

    full_read_c: cover property (@(posedge clk) data_last && addr_reg == 5'h11);
    short_read_c: cover property (@(posedge clk) data_last && addr_reg == 5'h07);
    qual_refuse_c: cover property (@(posedge clk) req_error);
    stall_c: cover property (@(posedge clk) data_valid && !data_ready);
    hs_read_c: cover property (@(posedge clk) data_last && high_speed && addr_reg == 5'h11);
endmodule

//--- rtl/field_check.sv
// Registers the class unchanged and legalises the subclass and endpoint-zero packet size fields.
`timescale 1ns/100ps
module field_check (
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic [7:0] class_in,
    input  wire logic [7:0] subclass_in,
    input  wire logic [7:0] packet_in,
    input  wire logic       high_speed,
    output logic      [7:0] class_out,
    output logic      [7:0] subclass_out,
    output logic      [7:0] packet_out
);
    function automatic logic packet_legal(input logic [7:0] p);
        packet_legal = (p == dev_desc_pkg::PACKET_8) || (p == dev_desc_pkg::PACKET_16) ||
                       (p == dev_desc_pkg::PACKET_32) || (p == dev_desc_pkg::PACKET_HS);
    endfunction

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            class_out    <= dev_desc_pkg::CLASS_PER_IFACE;
            subclass_out <= dev_desc_pkg::SUBCLASS_NONE;
            packet_out   <= dev_desc_pkg::PACKET_HS;
        end else begin
            class_out <= class_in; // [R12] [R13] [R14]
            // A zero class forces a zero subclass; assigned codes pass unchanged.
            if (class_in == dev_desc_pkg::CLASS_PER_IFACE) begin
                subclass_out <= dev_desc_pkg::SUBCLASS_NONE; // [R15]
            end else begin
                subclass_out <= subclass_in; // [R16]
            end
            // High speed only allows 64; an illegal size falls back to 8.
            if (high_speed) begin
                packet_out <= dev_desc_pkg::PACKET_HS; // [R7]
            end else if (packet_legal(packet_in)) begin
                packet_out <= packet_in; // [R17]
            end else begin
                packet_out <= dev_desc_pkg::PACKET_8; // [R17]
            end
        end
    end
endmodule

//--- tb/host_model.sv
// Host-side model that issues descriptor requests and consumes the returned bytes.
`timescale 1ns/100ps
module host_model (
    input  wire logic       clk,
    output logic            req_valid,
    output logic [7:0]      req_type,
    output logic [4:0]      req_length,
    output logic            data_ready,
    input  wire logic       req_ready,
    input  wire logic       req_error,
    input  wire logic       data_valid,
    input  wire logic [7:0] data_byte,
    input  wire logic       data_last
);
    // =========================================================================
    // Request and collection
    // =========================================================================
    logic       stall_en;
    int         seed;
    int         err_cycles;
    logic [7:0] got[$];
    logic       got_last[$];

    initial begin
        req_valid  = 1'b0;
        req_type   = 8'h00;
        req_length = 5'h00;
        data_ready = 1'b0;
        stall_en   = 1'b0;
        seed       = 32'hB311;
    end

    // A request with no data is still watched a few cycles so a stray byte or error shows up.
    task automatic fetch(input logic [7:0] kind, input logic [4:0] len, input int n);
        int guard;
        logic done;
        got.delete();
        got_last.delete();
        err_cycles = 0;
        @(negedge clk);
        req_valid  = 1'b1;
        req_type   = kind;
        req_length = len;
        guard = 0;
        while (req_ready !== 1'b1 && guard < 100) begin
            @(negedge clk);
            guard++;
        end
        @(negedge clk);
        req_valid  = 1'b0;
        req_type   = ~kind;
        req_length = ~len;
        guard = 0;
        done  = 1'b0;
        while (!done && guard < 400) begin
            data_ready = stall_en ? 1'($random(seed)) : 1'b1;
            #1;
            if (req_error === 1'b1) err_cycles++;
            if (data_valid === 1'b1 && data_ready) begin
                got.push_back(data_byte);
                got_last.push_back(data_last);
                if (data_last === 1'b1) done = 1'b1;
            end
            if (n == 0 && guard >= 4) done = 1'b1;
            guard++;
            @(negedge clk);
        end
    endtask
endmodule

//--- tb/test_device_descriptor_source.sv
// Self-checking bench for the device descriptor source.
`timescale 1ns/100ps
module test_device_descriptor_source;
    logic       clk;
    logic       reset_n;
    logic [1:0] speed;
    logic       qualifier_differs;
    logic [7:0] class_code;
    logic [7:0] subclass_code;
    logic [7:0] protocol_code;
    logic [7:0] packet_size_fs;
    logic [7:0] configs_hs;
    logic [7:0] configs_fs;
    logic       req_valid;
    logic [7:0] req_type;
    logic [4:0] req_length;
    logic       req_ready;
    logic       req_error;
    logic       qualifier_needed;
    logic       data_valid;
    logic [7:0] data_byte;
    logic       data_last;
    logic       data_ready;
    int         fail_count = 0;
    int         checks     = 0;
    int         seed       = 32'hB310;
    logic [7:0] pk[6]      = '{8'h08, 8'h10, 8'h20, 8'h40, 8'h11, 8'h00};

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    device_descriptor_source dut (.clk(clk), .reset_n(reset_n), .speed(speed),
        .qualifier_differs(qualifier_differs), .class_code(class_code), .subclass_code(subclass_code),
        .protocol_code(protocol_code), .packet_size_fs(packet_size_fs), .configs_hs(configs_hs),
        .configs_fs(configs_fs), .req_valid(req_valid), .req_type(req_type), .req_length(req_length),
        .req_ready(req_ready), .req_error(req_error), .qualifier_needed(qualifier_needed),
        .data_valid(data_valid), .data_byte(data_byte), .data_last(data_last), .data_ready(data_ready));

    host_model host (.clk(clk), .req_valid(req_valid), .req_type(req_type), .req_length(req_length),
        .data_ready(data_ready), .req_ready(req_ready), .req_error(req_error), .data_valid(data_valid),
        .data_byte(data_byte), .data_last(data_last));

    // =========================================================================
    // Checking helpers
    // =========================================================================
    task automatic end_sim();
        if (fail_count == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    function automatic logic [7:0] exp_byte(input int ofs);
        logic hs;
        hs = (speed == dev_desc_pkg::SPEED_HIGH);
        case (ofs)
            0:       return {3'h0, dev_desc_pkg::DESC_LEN};
            1:       return dev_desc_pkg::TYPE_DEVICE;
            2:       return 8'h00;
            3:       return 8'h02;
            4:       return class_code;
            5:       return (class_code == 8'h00) ? 8'h00 : subclass_code;
            6:       return protocol_code;
            7:       return hs ? 8'h40 : ((packet_size_fs inside {8'h08, 8'h10, 8'h20, 8'h40}) ? packet_size_fs : 8'h08);
            8:       return dev_desc_pkg::VENDOR_ID[7:0];
            9:       return dev_desc_pkg::VENDOR_ID[15:8];
            10:      return dev_desc_pkg::PRODUCT_ID[7:0];
            11:      return dev_desc_pkg::PRODUCT_ID[15:8];
            12:      return dev_desc_pkg::DEVICE_RELEASE[7:0];
            13:      return dev_desc_pkg::DEVICE_RELEASE[15:8];
            default: return hs ? configs_hs : configs_fs;
        endcase
    endfunction

    // Input fields pass through registers, so they change only while idle and get time to settle.
    task automatic setup(input logic [1:0] sp, input logic [7:0] cls, input logic [7:0] sub, input logic [7:0] pkt);
        @(negedge clk);
        speed             = sp;
        qualifier_differs = 1'($random(seed));
        class_code        = cls;
        subclass_code     = sub;
        protocol_code     = 8'($random(seed));
        packet_size_fs    = pkt;
        configs_hs        = 8'($random(seed));
        configs_fs        = 8'($random(seed));
        repeat (3) @(negedge clk);
        check({7'h00, qualifier_needed}, {7'h00, sp == 2'h2 && qualifier_differs}, "qualifier flag");
    endtask

    task automatic run_desc(input logic [4:0] len);
        int n;
        n = (len > 5'd18) ? 18 : int'(len);
        host.fetch(8'h01, len, n);
        check(8'(host.got.size()), 8'(n), "byte count");
        check(8'(host.err_cycles), 8'h00, "error on device request");
        for (int i = 0; i < n && i < host.got.size(); i++) begin
            if (!(i inside {14, 15, 16})) check(host.got[i], exp_byte(i), "descriptor byte");
            check({7'h00, host.got_last[i]}, {7'h00, i == n - 1}, "last flag");
        end
    endtask

    task automatic run_refuse(input logic [7:0] kind, input logic [7:0] exp_err);
        host.fetch(kind, 5'd18, 0);
        check(8'(host.err_cycles), exp_err, "request error");
        check(8'(host.got.size()), 8'h00, "data on refused request");
        check({7'h00, req_ready}, 8'h01, "ready after request");
    endtask

    // =========================================================================
    // Main sequence
    // =========================================================================
    initial begin
        reset_n = 1'b0;
        speed = 2'h1;
        qualifier_differs = 1'b0;
        class_code = 8'h00;
        subclass_code = 8'h00;
        protocol_code = 8'h00;
        packet_size_fs = 8'h08;
        configs_hs = 8'h01;
        configs_fs = 8'h01;
        repeat (5) @(negedge clk);
        reset_n = 1'b1;
        repeat (2) @(negedge clk);
        for (int sp = 0; sp < 3; sp++) begin
            setup(2'(sp), 8'h00, 8'h5A, 8'h11);
            run_desc(5'd18);
            run_refuse(dev_desc_pkg::TYPE_QUALIFIER, (sp == 2) ? 8'h00 : 8'h01);
            run_refuse(8'h02, 8'h01);
        end
        foreach (pk[i]) begin
            setup(2'h1, (i % 2) ? 8'hFF : 8'hFE, 8'h3C, pk[i]);
            run_desc((i == 0) ? 5'd0 : (i == 1) ? 5'd1 : (i == 2) ? 5'd31 : 5'd17);
        end
        host.stall_en = 1'b1;
        repeat (12) begin
            setup(2'($unsigned($random(seed)) % 3), 8'($random(seed)), 8'($random(seed)),
                  pk[$unsigned($random(seed)) % 6]);
            run_desc(5'($random(seed)));
        end
        end_sim();
    end

    initial begin
        #(25 * 20000);
        fail_count++;
        end_sim();
    end
endmodule
